// ==== design/rsa_fault_flag.sv ====
/*
 * One fault channel: present flag and latched flag.
 * Assumes the condition input is synchronous to clk_i.
 */
`timescale 1ns/1ps
module rsa_fault_flag (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // condition and clear
    input  wire logic cond_i,
    input  wire logic clear_i,
    // flags
    output logic      active_o,
    output logic      latched_o
);

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_o <= 1'b0;
        end else begin
            active_o <= cond_i; // [R12]
        end
    end

    // set wins over the read clear so a fresh event is never lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_o <= 1'b0;
        end else if (cond_i) begin
            latched_o <= 1'b1; // [R12]
        end else if (clear_i) begin
            latched_o <= 1'b0;
        end
    end

    chk_set_wins_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        cond_i |=> latched_o && active_o)
        else $error("latched flag missed a condition");
    chk_hold_no_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        latched_o && !clear_i |=> latched_o)
        else $error("latched flag dropped without a read");

endmodule

// ==== design/rsa_pkg.sv ====
/*
 * Constants, offsets, field positions and codes for the span select and fault
 * status register bank. Assumes a 32-bit classic Wishbone slave port.
 */
// Overview of operation
// R1: Span codes 0000b to 0100b pick bipolar spans of 3, 2.5, 1.5, 1.25 and 0.625 times the reference.
// R2: Span codes 1000b to 1011b pick unipolar spans of 3, 2.5, 1.5 and 1.25 times the reference; other codes are invalid.
// R3: Bit 6 of the span register turns the internal reference off when one, and resets to zero.
// R4: Every reserved bit of both registers reads zero and ignores writes.
// R5: Status bit 0 is the OR of the four latched fault flags.
// R6: Status bit 15 shows the present low analog supply condition, zero after reset.
// R7: Status bit 14 shows the present high analog supply condition, zero after reset.
// R8: Status bits 11 and 10 show the present low and high input conditions.
// R9: Status bits 7 and 6 are latched low and high analog supply faults, zero after reset.
// R10: Status bits 5 and 4 are latched low and high input faults, zero after reset.
// R11: The span and reference register sits at byte address 0x14.
// R12: Present flags follow the condition each cycle; latched flags hold until the status word is read.
package rsa_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RSA_SPAN_ADDR   = 8'h14;
    localparam logic [7:0] RSA_STATUS_ADDR = 8'h20;
    localparam logic [7:0] RSA_IRQ_ST_ADDR = 8'h40;
    localparam logic [7:0] RSA_IRQ_MK_ADDR = 8'h44;
    localparam int         RSA_ADDR_W      = 8;

    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int RSA_REF_OFF_BIT  = 6;
    localparam int RSA_SPAN_LSB     = 0;
    localparam int RSA_SPAN_W       = 4;
    localparam int RSA_ANY_BIT      = 0;
    localparam int RSA_IN_HI_LBIT   = 4;
    localparam int RSA_IN_LO_LBIT   = 5;
    localparam int RSA_SUP_HI_LBIT  = 6;
    localparam int RSA_SUP_LO_LBIT  = 7;
    localparam int RSA_IN_HI_ABIT   = 10;
    localparam int RSA_IN_LO_ABIT   = 11;
    localparam int RSA_SUP_HI_ABIT  = 14;
    localparam int RSA_SUP_LO_ABIT  = 15;
    localparam int RSA_NUM_FAULTS   = 4;

    localparam logic [3:0] RSA_SPAN_RESET    = 4'h0;
    localparam logic       RSA_REF_OFF_RESET = 1'b0;
    localparam logic [3:0] RSA_MASK_RESET    = 4'h0;

    // ------------------------------------------------------------------
    // span decode
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RSA_BI_3X0   = 4'b0000,
        RSA_BI_2X5   = 4'b0001,
        RSA_BI_1X5   = 4'b0010,
        RSA_BI_1X25  = 4'b0011,
        RSA_BI_0X625 = 4'b0100,
        RSA_UNI_3X0  = 4'b1000,
        RSA_UNI_2X5  = 4'b1001,
        RSA_UNI_1X5  = 4'b1010,
        RSA_UNI_1X25 = 4'b1011
    } rsa_span_t;

    // gain index 0..4 = 3, 2.5, 1.5, 1.25, 0.625 times reference
    typedef logic [2:0] rsa_gain_t;

endpackage

// ==== design/rsa_regs.sv ====
/*
 * Span select / reference control register and fault status word, with
 * interrupt status and mask, on a classic Wishbone slave.
 * Assumes fault conditions arrive synchronous to clk_i from the comparators.
 */
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module rsa_regs
    import rsa_pkg::*;
(
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [rsa_pkg::RSA_ADDR_W-1:0] adr_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [31:0]                 dat_i,
    output logic      [31:0]                 dat_o,
    output logic                             ack_o,
    output logic                             err_o,
    // fault conditions
    input  wire logic                        supply_low_i,
    input  wire logic                        supply_high_i,
    input  wire logic                        input_low_i,
    input  wire logic                        input_high_i,
    // analog controls
    output logic      [3:0]                  span_code_o,
    output logic                             internal_reference_off_o,
    output logic                             span_bipolar_o,
    output logic      [2:0]                  span_gain_o,
    output logic                             span_valid_o,
    // interrupt
    output logic                             irq_o
);
    import rsa_pkg::*;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic        req;
    logic        wr;
    logic        rd;
    logic        hit_span;
    logic        hit_stat;
    logic        hit_ist;
    logic        hit_imk;
    logic        hit_any;
    logic [31:0] next_dat;

    // single-cycle answer: ack one edge after the request, then dropped
    assign req      = cyc_i && stb_i && !ack_o && !err_o;
    assign hit_span = adr_i == RSA_SPAN_ADDR; // [R11]
    assign hit_stat = adr_i == RSA_STATUS_ADDR;
    assign hit_ist  = adr_i == RSA_IRQ_ST_ADDR;
    assign hit_imk  = adr_i == RSA_IRQ_MK_ADDR;
    assign hit_any  = hit_span || hit_stat || hit_ist || hit_imk;
    assign wr       = req && we_i && hit_any;
    assign rd       = req && !we_i && hit_any;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req && hit_any;
            err_o <= req && !hit_any;
        end
    end

    // ------------------------------------------------------------------
    // span and reference control
    // ------------------------------------------------------------------
    logic [3:0] span_code;
    logic       ref_off;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            span_code <= RSA_SPAN_RESET;
            ref_off   <= RSA_REF_OFF_RESET; // [R3]
        end else if (wr && hit_span && sel_i[0]) begin
            span_code <= dat_i[RSA_SPAN_LSB +: RSA_SPAN_W];
            ref_off   <= dat_i[RSA_REF_OFF_BIT]; // [R3]
        end
    end

    assign span_code_o              = span_code;
    assign internal_reference_off_o = ref_off;

    // invalid codes keep the last valid decode, so the front end never sees a gap
    logic       next_bipolar;
    logic [2:0] next_gain;
    logic       next_valid;

    always_comb begin
        next_bipolar = 1'b1;
        next_gain    = 3'h0;
        next_valid   = 1'b1;
        case (span_code)
            RSA_BI_3X0:   begin next_bipolar = 1'b1; next_gain = 3'h0; end // [R1]
            RSA_BI_2X5:   begin next_bipolar = 1'b1; next_gain = 3'h1; end // [R1]
            RSA_BI_1X5:   begin next_bipolar = 1'b1; next_gain = 3'h2; end // [R1]
            RSA_BI_1X25:  begin next_bipolar = 1'b1; next_gain = 3'h3; end // [R1]
            RSA_BI_0X625: begin next_bipolar = 1'b1; next_gain = 3'h4; end // [R1]
            RSA_UNI_3X0:  begin next_bipolar = 1'b0; next_gain = 3'h0; end // [R2]
            RSA_UNI_2X5:  begin next_bipolar = 1'b0; next_gain = 3'h1; end // [R2]
            RSA_UNI_1X5:  begin next_bipolar = 1'b0; next_gain = 3'h2; end // [R2]
            RSA_UNI_1X25: begin next_bipolar = 1'b0; next_gain = 3'h3; end // [R2]
            default:      begin next_valid = 1'b0; end // [R2]
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            span_bipolar_o <= 1'b1;
            span_gain_o    <= 3'h0;
            span_valid_o   <= 1'b1;
        end else begin
            span_valid_o <= next_valid;
            if (next_valid) begin
                span_bipolar_o <= next_bipolar;
                span_gain_o    <= next_gain;
            end
        end
    end

    // ------------------------------------------------------------------
    // fault channels
    // ------------------------------------------------------------------
    logic [RSA_NUM_FAULTS-1:0] cond;
    logic [RSA_NUM_FAULTS-1:0] act;
    logic [RSA_NUM_FAULTS-1:0] lat;
    logic                      stat_read;

    // channel order: 3 supply low, 2 supply high, 1 input low, 0 input high
    assign cond      = {supply_low_i, supply_high_i, input_low_i, input_high_i};
    assign stat_read = rd && hit_stat; // [R12]

    genvar g;
    generate
        for (g = 0; g < RSA_NUM_FAULTS; g++) begin : g_fault
            rsa_fault_flag u_flag (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .cond_i    (cond[g]),
                .clear_i   (stat_read),
                .active_o  (act[g]),
                .latched_o (lat[g])
            );
        end
    endgenerate

    logic [31:0] status_word;

    always_comb begin
        status_word                  = 32'h0000_0000; // [R4]
        status_word[RSA_SUP_LO_ABIT] = act[3]; // [R6]
        status_word[RSA_SUP_HI_ABIT] = act[2]; // [R7]
        status_word[RSA_IN_LO_ABIT]  = act[1]; // [R8]
        status_word[RSA_IN_HI_ABIT]  = act[0]; // [R8]
        status_word[RSA_SUP_LO_LBIT] = lat[3]; // [R9]
        status_word[RSA_SUP_HI_LBIT] = lat[2]; // [R9]
        status_word[RSA_IN_LO_LBIT]  = lat[1]; // [R10]
        status_word[RSA_IN_HI_LBIT]  = lat[0]; // [R10]
        status_word[RSA_ANY_BIT]     = |lat; // [R5]
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    logic [RSA_NUM_FAULTS-1:0] irq_stat;
    logic [RSA_NUM_FAULTS-1:0] irq_mask;
    logic [RSA_NUM_FAULTS-1:0] w1c;

    assign w1c = (wr && hit_ist && sel_i[0]) ? dat_i[RSA_NUM_FAULTS-1:0] : '0;

    // new event beats the write-one-to-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~w1c) | cond;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= RSA_MASK_RESET;
        end else if (wr && hit_imk && sel_i[0]) begin
            irq_mask <= dat_i[RSA_NUM_FAULTS-1:0];
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        next_dat = 32'h0000_0000; // [R4]
        if (hit_span) begin
            next_dat[RSA_SPAN_LSB +: RSA_SPAN_W] = span_code;
            next_dat[RSA_REF_OFF_BIT]            = ref_off; // [R3]
        end else if (hit_stat) begin
            next_dat = status_word;
        end else if (hit_ist) begin
            next_dat[RSA_NUM_FAULTS-1:0] = irq_stat;
        end else if (hit_imk) begin
            next_dat[RSA_NUM_FAULTS-1:0] = irq_mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            dat_o <= next_dat;
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_span_read;
        rd && hit_span;
    endsequence

    sequence s_stat_read;
        rd && hit_stat;
    endsequence

    chk_span_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        s_span_read |=> ack_o && dat_o[31:7] == 25'h0 && dat_o[5:4] == 2'h0)
        else $error("span register reserved bits not zero");
    chk_stat_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        s_stat_read |=> ack_o && dat_o[31:16] == 16'h0 && dat_o[13:12] == 2'h0
                        && dat_o[9:8] == 2'h0 && dat_o[3:1] == 3'h0)
        else $error("status reserved bits not zero");
    chk_summary_or: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        s_stat_read |=> dat_o[0] == |dat_o[7:4])
        else $error("summary bit differs from OR of latched flags");
    chk_span_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        wr && hit_span && sel_i[0] |=> span_code == $past(dat_i[3:0])
                                       && ref_off == $past(dat_i[6]))
        else $error("span write not stored");
    chk_supply_low_live: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
        supply_low_i ##1 s_stat_read |=> dat_o[15] && dat_o[7])
        else $error("supply low flags not shown");
    chk_supply_high_live: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
        supply_high_i ##1 s_stat_read |=> dat_o[14] && dat_o[6])
        else $error("supply high flags not shown");
    chk_input_low_live: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        input_low_i ##1 s_stat_read |=> dat_o[11] && dat_o[5])
        else $error("input low flags not shown");
    chk_read_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        (s_stat_read and (cond == '0)) |=> lat == '0)
        else $error("latched flags not cleared by status read");
    chk_invalid_span: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        span_code[2] && span_code[3] |=> !span_valid_o)
        else $error("invalid span code decoded as valid");
    chk_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        req && hit_any |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle");
    chk_input_high_live: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        input_high_i ##1 s_stat_read |=> dat_o[10] && dat_o[4])
        else $error("input high flags not shown");
    chk_read_keeps_live: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        s_stat_read |=> (lat & $past(cond)) == $past(cond))
        else $error("latched flag cleared while condition present");
    chk_active_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        1'b1 |=> act == $past(cond))
        else $error("active flags do not follow conditions");

    // ------------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------------
    sequence s_bus_take;
        req && hit_any;
    endsequence

    sequence s_bus_refuse;
        req && !hit_any;
    endsequence

    // an unmapped access must neither ack nor touch a stored field
    chk_refuse_err: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        s_bus_refuse |=> err_o && !ack_o && dat_o == 32'h0)
        else $error("unmapped access not refused");
    chk_refuse_no_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        s_bus_refuse |=> $stable(span_code) && $stable(ref_off) && $stable(irq_mask))
        else $error("unmapped write changed a register");
    chk_take_one_answer: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        s_bus_take |=> ack_o && !err_o)
        else $error("mapped access not acked");
    chk_idle_data_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        !ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside ack");

    // ------------------------------------------------------------------
    // span checks
    // ------------------------------------------------------------------
    sequence s_span_write;
        wr && hit_span && sel_i[0];
    endsequence

    chk_span_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        !(wr && hit_span && sel_i[0]) |=> $stable(span_code) && $stable(ref_off))
        else $error("span register changed without a write");
    chk_span_output: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        s_span_write |=> ##1 internal_reference_off_o == $past(dat_i[RSA_REF_OFF_BIT], 2))
        else $error("reference control output lost");
    chk_span_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        s_span_read |=> dat_o[6] == $past(ref_off) && dat_o[3:0] == $past(span_code))
        else $error("span register read back wrong");
    chk_bipolar_decode: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        !span_code[3] && span_code[2:0] <= 3'h4
        |=> span_valid_o && span_bipolar_o && span_gain_o == $past(span_code[2:0]))
        else $error("bipolar span decoded wrong");
    chk_unipolar_decode: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        span_code[3] && !span_code[2]
        |=> span_valid_o && !span_bipolar_o && span_gain_o == {1'b0, $past(span_code[1:0])})
        else $error("unipolar span decoded wrong");
    chk_gap_codes: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        !span_code[3] && span_code[2] && span_code[1:0] != 2'h0 |=> !span_valid_o)
        else $error("code between the span groups decoded as valid");
    chk_invalid_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        !next_valid |=> $stable(span_bipolar_o) && $stable(span_gain_o))
        else $error("invalid code disturbed the last decode");

    // ------------------------------------------------------------------
    // reset checks
    // ------------------------------------------------------------------
    // these run through reset on purpose, so they carry no disable
    chk_reset_flags: assert property (@(posedge clk_i) // [R6] [R7] [R9] [R10]
        rst_i |=> act == '0 && lat == '0 && irq_stat == '0)
        else $error("fault flags not cleared by reset");
    chk_reset_span: assert property (@(posedge clk_i) // [R3]
        rst_i |=> span_code == RSA_SPAN_RESET && ref_off == RSA_REF_OFF_RESET && !ack_o && !err_o)
        else $error("span register not cleared by reset");

endmodule

// ==== testbench/rsa_host.sv ====
/*
 * Host model: classic Wishbone master issuing single register cycles.
 * Assumes a slave that answers every cycle with ack or err.
 */
`timescale 1ns/1ps
module rsa_host (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    input  wire logic        err_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // call just after a rising edge; request holds until ack or err
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output logic e);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1 && err_i !== 1'b1);
        q = dat_i;
        e = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // idle cycle so the slave sees stb low between requests
        @(posedge clk_i);
    endtask
endmodule

// ==== testbench/tb_top.sv ====
/*
 * Self-checking bench for the span and fault status registers.
 * Assumes rsa_regs and the rsa_host master model.
 */
`timescale 1ns/1ps
module tb_top;
    import rsa_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, err, irq, e, refo, bip, val;
    logic [7:0]  adr;
    logic [3:0]  sel, conds, c, code, m_code, m_lat, m_irq, m_mask;
    logic [2:0]  gain, m_gain;
    logic [31:0] wd, rdat, q, d;
    logic        m_ref, m_bip, m_val;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          seed = 99459;

    always #2 clk_i = ~clk_i;

    rsa_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .err_o(err),
        .supply_low_i(conds[3]), .supply_high_i(conds[2]), .input_low_i(conds[1]),
        .input_high_i(conds[0]), .span_code_o(code), .internal_reference_off_o(refo),
        .span_bipolar_o(bip), .span_gain_o(gain), .span_valid_o(val), .irq_o(irq));

    rsa_host host_u (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wd), .dat_i(rdat), .ack_i(ack), .err_i(err));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 4'hF, 32'h0, q, e);
        check({31'h0, e}, 32'h0);
        check(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
        host_u.xfer(1'b1, a, s, v, q, e);
    endtask

    // model of the span decode; an unknown code keeps the last decode
    task automatic upd_span(input logic [3:0] k);
        m_code = k;
        m_val = (k <= 4'h4) || (k >= 4'h8 && k <= 4'hB);
        if (m_val) begin
            m_bip = ~k[3];
            m_gain = k[2:0];
        end
    endtask

    task automatic chk_span;
        check({22'h0, code, refo, bip, gain, val}, {22'h0, m_code, m_ref, m_bip, m_gain, m_val});
    endtask

    function automatic logic [31:0] stat(input logic [3:0] a, input logic [3:0] l);
        return {16'h0, a[3:2], 2'b00, a[1:0], 2'b00, l, 3'b000, |l};
    endfunction

    initial begin
        conds = 4'h0;
        m_ref = 1'b0;
        m_bip = 1'b1;
        m_gain = 3'h0;
        m_lat = 4'h0;
        m_irq = 4'h0;
        m_code = 4'h0;
        m_val = 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        chk_span();
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h44, 32'h0);
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            d[3:0] = i[3:0];
            wr(8'h14, 4'hF, d);
            m_ref = d[6];
            upd_span(i[3:0]);
            rd(8'h14, {25'h0, m_ref, 2'b00, m_code});
            chk_span();
        end
        // byte 0 not enabled: nothing changes
        wr(8'h14, 4'hE, 32'hFFFF_FFF1);
        rd(8'h14, {25'h0, m_ref, 2'b00, m_code});
        host_u.xfer(1'b0, 8'h18, 4'hF, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        wr(8'h20, 4'hF, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        for (int i = 0; i < 8; i++) begin
            m_mask = 4'($random(seed));
            wr(8'h44, 4'hF, {28'h0, m_mask});
            rd(8'h44, {28'h0, m_mask});
            c = 4'($random(seed));
            conds <= c;
            tick(3);
            m_lat = m_lat | c;
            m_irq = m_irq | c;
            check({31'h0, irq}, {31'h0, |(m_irq & m_mask)});
            rd(8'h20, stat(c, m_lat));
            // condition held through the read keeps its latch
            m_lat = c;
            conds <= 4'h0;
            tick(3);
            rd(8'h20, stat(4'h0, m_lat));
            m_lat = 4'h0;
            rd(8'h20, stat(4'h0, 4'h0));
            rd(8'h40, {28'h0, m_irq});
            wr(8'h40, 4'hF, {28'h0, m_irq});
            m_irq = 4'h0;
            check({31'h0, irq}, 32'h0);
            rd(8'h40, 32'h0);
        end
        // mid-run reset clears flags, span and mask
        conds <= 4'hF;
        wr(8'h14, 4'hF, 32'h0000_004B);
        conds <= 4'h0;
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        m_ref = 1'b0;
        upd_span(4'h0);
        chk_span();
        rd(8'h20, 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h44, 32'h0);
        tally_and_finish();
    end
endmodule
